// ===== hdl/smul_array.sv
// Combinational unsigned 8x8 shift-and-add array.
// Assumes the caller registers the product; no state lives here.
module smul_array
  import smul_pkg::*;
(
  // Operands
  input wire logic [OPND_W-1:0] a_i,
  input wire logic [OPND_W-1:0] b_i,
  // Product
  output logic [PROD_W-1:0] p_o
);

  logic [PROD_W-1:0] acc [0:OPND_W];
  logic [PROD_W-1:0] a_ext;

  assign a_ext = {{(PROD_W-OPND_W){1'b0}}, a_i};
  assign acc[0] = PROD_ZERO;

  // ----------------------------------------------------------------
  // One partial product per multiplier bit
  // ----------------------------------------------------------------
  // Zero extension keeps the sum unsigned; no carry can leave 16 bits
  for (genvar i = 0; i < OPND_W; i++) begin : g_row
    logic [PROD_W-1:0] row;
    assign row = b_i[i] ? (a_ext << i) : PROD_ZERO;
    assign acc[i+1] = acc[i] + row;
  end

  assign p_o = acc[OPND_W];

endmodule : smul_array

// ===== hdl/smul_pkg.sv
// Shared constants and carriers for the single-cycle 8x8 product unit.
// Assumes the core decoder and data memory run on the same core clock.
package smul_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned OPND_W = 8;
  localparam int unsigned PROD_W = 16;
  localparam int unsigned FLAG_W = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [OPND_W-1:0] PROD_HI_RST = 8'h00;
  localparam logic [OPND_W-1:0] PROD_LO_RST = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;
  localparam logic [PROD_W-1:0] PROD_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Flag field positions in the ALU flag register
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_CARRY_POS = 0;
  localparam int unsigned FLAG_DCARRY_POS = 1;
  localparam int unsigned FLAG_ZERO_POS = 2;
  localparam int unsigned FLAG_OVF_POS = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned MUL_LATENCY = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic go;
    logic [OPND_W-1:0] working_register;
    logic [OPND_W-1:0] fdata;
  } smul_req_t;

  typedef struct packed {
    logic hi_we;
    logic lo_we;
    logic [OPND_W-1:0] data;
  } smul_pwr_t;

  typedef struct packed {
    logic we;
    logic [FLAG_W-1:0] data;
  } smul_flag_wr_t;

  // ----------------------------------------------------------------
  // Byte split of a product
  // ----------------------------------------------------------------
  function automatic logic [OPND_W-1:0] smul_hi(input logic [PROD_W-1:0] p);
    return p[PROD_W-1:OPND_W];
  endfunction : smul_hi

  function automatic logic [OPND_W-1:0] smul_lo(input logic [PROD_W-1:0] p);
    return p[OPND_W-1:0];
  endfunction : smul_lo

endpackage : smul_pkg

// ===== hdl/smul_unit.sv
// What this block does
// - Unsigned operands, full unsigned 16-bit product
// - Multiply completes in one instruction cycle
// - High byte to high half, low to low
// - Multiply never changes any ALU flag
// - Operands: working register and addressed file byte
//
// Top of the hardware product unit inside the ALU.
// Assumes one multiply request per instruction cycle, operands valid with it,
// and all requests synchronous to mclk_i.
module smul_unit
  import smul_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Multiply request from the decoder
  input wire smul_req_t req_i,
  // Direct writes to the product pair
  input wire smul_pwr_t pwr_i,
  // Flag register writes from other ALU operations
  input wire smul_flag_wr_t flag_wr_i,
  // Product pair
  output logic [OPND_W-1:0] product_high_byte_o,
  output logic [OPND_W-1:0] product_low_byte_o,
  // Completion and flags
  output logic mul_done_o,
  output logic [FLAG_W-1:0] alu_flag_register_o
);

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [PROD_W-1:0] prod;

  // operand routing
  // Working register on one side, file byte on the other
  smul_array u_array (
    .a_i(req_i.working_register),
    .b_i(req_i.fdata),
    .p_o(prod)
  );

  // ----------------------------------------------------------------
  // Product register pair
  // ----------------------------------------------------------------
  logic [OPND_W-1:0] hi_q;
  logic [OPND_W-1:0] hi_d;
  logic [OPND_W-1:0] lo_q;
  logic [OPND_W-1:0] lo_d;
  logic done_q;
  logic done_d;

  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    done_d = 1'b0;
    // direct access
    // A multiply in the same cycle wins over a direct write
    if (pwr_i.hi_we) begin
      hi_d = pwr_i.data;
    end
    if (pwr_i.lo_we) begin
      lo_d = pwr_i.data;
    end
    if (req_i.go) begin
      hi_d = smul_hi(prod);
      lo_d = smul_lo(prod);
      done_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hi_q <= PROD_HI_RST;
      lo_q <= PROD_LO_RST;
      done_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // ALU flag register
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] flag_d;

  always_comb begin
    flag_d = flag_q;
    // flags untouched
    // Only the other ALU paths write flags; the multiply has no path here
    if (flag_wr_i.we) begin
      flag_d = flag_wr_i.data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flag_q <= FLAG_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign product_high_byte_o = hi_q;
  assign product_low_byte_o = lo_q;
  assign mul_done_o = done_q;
  assign alu_flag_register_o = flag_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  logic [PROD_W-1:0] ref_prod;
  assign ref_prod = PROD_W'(req_i.working_register) * PROD_W'(req_i.fdata);

  sequence s_mul;
    req_i.go;
  endsequence

  sequence s_idle_hi;
    !req_i.go && !pwr_i.hi_we;
  endsequence

  sequence s_idle_lo;
    !req_i.go && !pwr_i.lo_we;
  endsequence

  sequence s_idle_both;
    !req_i.go && !pwr_i.hi_we && !pwr_i.lo_we;
  endsequence

  a_full_product: assert property (
    s_mul |=> {product_high_byte_o, product_low_byte_o} == $past(ref_prod))
    else $error("product pair does not equal the unsigned product");

  a_one_cycle_done: assert property (
    s_mul |=> mul_done_o ##1 (mul_done_o == $past(req_i.go)))
    else $error("multiply did not complete in one cycle");

  a_done_cause: assert property (
    mul_done_o |-> $past(req_i.go))
    else $error("done pulse without a multiply");

  a_hi_byte_place: assert property (
    s_mul |=> product_high_byte_o == $past(ref_prod[15:8]))
    else $error("high byte misplaced");

  a_lo_byte_place: assert property (
    s_mul |=> product_low_byte_o == $past(ref_prod[7:0]))
    else $error("low byte misplaced");

  a_flags_kept: assert property (
    (req_i.go && !flag_wr_i.we) |=> $stable(alu_flag_register_o))
    else $error("multiply changed the flag register");

  a_operand_src: assert property (
    (s_mul ##1 s_mul) |=>
      {product_high_byte_o, product_low_byte_o} == $past(ref_prod))
    else $error("back to back multiply used stale operands");

  a_hold_hi: assert property (
    s_idle_hi |=> $stable(product_high_byte_o))
    else $error("high product byte changed without cause");

  a_hold_lo: assert property (
    s_idle_lo |=> $stable(product_low_byte_o))
    else $error("low product byte changed without cause");

  a_write_lo: assert property (
    (pwr_i.lo_we && !req_i.go) |=> product_low_byte_o == $past(pwr_i.data))
    else $error("direct write to low byte lost");

  a_write_hi: assert property (
    (pwr_i.hi_we && !req_i.go) |=> product_high_byte_o == $past(pwr_i.data))
    else $error("direct write to high byte lost");

  a_write_both: assert property (
    (pwr_i.hi_we && pwr_i.lo_we && !req_i.go) |=>
      {product_high_byte_o, product_low_byte_o} == {2{$past(pwr_i.data)}})
    else $error("direct write to both bytes lost");

  // Pair still holds the product one idle cycle later
  a_pair_held: assert property (
    (s_mul ##1 s_idle_both) |=>
      {product_high_byte_o, product_low_byte_o} == $past(ref_prod, 2))
    else $error("product pair lost after an idle cycle");

  a_done_idle: assert property (
    !req_i.go |=> !mul_done_o)
    else $error("done raised without a multiply");

  a_flag_write: assert property (
    flag_wr_i.we |=> alu_flag_register_o == $past(flag_wr_i.data))
    else $error("flag register write lost");

  // Independent of the reference product: all ones must not sign-extend
  a_max_product: assert property (
    (req_i.go && req_i.working_register == 8'hFF && req_i.fdata == 8'hFF) |=>
      {product_high_byte_o, product_low_byte_o} == 16'hFE01)
    else $error("all-ones operands gave a wrong product");

  a_zero_operand: assert property (
    (req_i.go && (req_i.working_register == '0 || req_i.fdata == '0)) |=>
      {product_high_byte_o, product_low_byte_o} == PROD_ZERO)
    else $error("zero operand gave a nonzero product");

  // Reset must act even though the other checks are off during it
  a_reset_values: assert property (
    disable iff (1'b0)
    rst_i |=> (product_high_byte_o == PROD_HI_RST && product_low_byte_o == PROD_LO_RST &&
      !mul_done_o && alu_flag_register_o == FLAG_RST))
    else $error("reset did not clear the unit");

endmodule : smul_unit

// ===== verification/smul_core_model.sv
// Decoder and data memory model feeding the product unit.
// Assumes the bench drives go, working value and address after an edge.
module smul_core_model
  import smul_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Instruction from the bench
  input wire logic go_i,
  input wire logic [OPND_W-1:0] working_register_i,
  input wire logic [OPND_W-1:0] addr_i,
  // Request to the unit
  output smul_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [OPND_W-1:0] mem [256];
  smul_req_t last_q = '0;
  // working value and addressed byte
  // Idle operands flip each cycle so stale data never looks valid
  always_comb begin
    req_o = go_i ? {1'b1, working_register_i, mem[addr_i]} : {1'b0, ~last_q.working_register, ~last_q.fdata};
  end
  always_ff @(posedge mclk_i) begin
    last_q <= req_o;
  end
endmodule : smul_core_model

// ===== verification/testbench.sv
// Self-checking bench for the single-cycle 8x8 product unit.
// Assumes the core model stands in for decoder and data memory.
module testbench
  import smul_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic [7:0] working_register = 8'h00;
  logic [7:0] addr = 8'h00;
  smul_pwr_t pwr = '0;
  smul_flag_wr_t fwr = '0;
  smul_req_t req;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [7:0] flags;
  logic done;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  smul_core_model u_smul_core_model (.mclk_i(mclk_i), .go_i(go), .working_register_i(working_register),
    .addr_i(addr), .req_o(req));
  smul_unit u_smul_unit (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .pwr_i(pwr),
    .flag_wr_i(fwr), .product_high_byte_o(hi), .product_low_byte_o(lo),
    .mul_done_o(done), .alu_flag_register_o(flags));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge mclk_i);
    #5;
  endtask : step
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Leaves go high so callers may chain multiplies back to back
  task automatic mul(input logic [7:0] w, input logic [7:0] f, output logic [15:0] p);
    addr = f ^ 8'h5A;
    u_smul_core_model.mem[addr] = f;
    working_register = w;
    go = 1'b1;
    step();
    p = {hi, lo};
    chk(32'(done), 32'h0000_0001);
  endtask : mul
  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_tbl();
    logic [7:0] w [6] = '{8'h00, 8'hFF, 8'h80, 8'h01, 8'hFF, 8'h0F};
    logic [7:0] f [6] = '{8'h00, 8'hFF, 8'h02, 8'hFF, 8'h01, 8'h11};
    logic [15:0] p;
    chk({8'h00, flags, hi, lo}, {8'h00, FLAG_RST, PROD_HI_RST, PROD_LO_RST});
    for (int i = 0; i < 6; i++) begin
      mul(w[i], f[i], p);
      chk(32'(p), 32'(w[i]) * 32'(f[i]));
      chk(32'(hi), (32'(w[i]) * 32'(f[i])) >> 8);
    end
    go = 1'b0;
    step();
    chk({15'h0000, done, hi, lo}, 32'h0000_00FF);
    $display("test table done");
  endtask : t_tbl
  task automatic t_flags();
    logic [15:0] p;
    fwr = '{we: 1'b1, data: 8'hA5};
    step();
    fwr.we = 1'b0;
    mul(8'h00, 8'h37, p);
    mul(8'hFF, 8'hFF, p);
    chk(32'(flags), 32'h0000_00A5);
    // Flag write sharing a cycle with a multiply still lands
    fwr = '{we: 1'b1, data: 8'h3C};
    mul(8'h0F, 8'h0F, p);
    fwr.we = 1'b0;
    go = 1'b0;
    chk(32'(flags), 32'h0000_003C);
    chk(32'(p), 32'h0000_00E1);
    $display("test flags done");
  endtask : t_flags
  task automatic t_direct();
    logic [15:0] p;
    pwr = '{hi_we: 1'b0, lo_we: 1'b1, data: 8'h3C};
    step();
    pwr = '{hi_we: 1'b1, lo_we: 1'b0, data: 8'hC3};
    step();
    chk({16'h0000, hi, lo}, 32'h0000_C33C);
    // Write shares the cycle with a multiply and is lost
    pwr = '{hi_we: 1'b1, lo_we: 1'b1, data: 8'h99};
    mul(8'h10, 8'h10, p);
    go = 1'b0;
    pwr = '0;
    step();
    step();
    chk({16'h0000, hi, lo}, 32'h0000_0100);
    $display("test direct done");
  endtask : t_direct
  task automatic t_reset();
    pwr = '{hi_we: 1'b1, lo_we: 1'b1, data: 8'h5A};
    step();
    pwr = '0;
    chk({16'h0000, hi, lo}, 32'h0000_5A5A);
    rst_i = 1'b1;
    step();
    chk({8'h00, flags, hi, lo}, {8'h00, FLAG_RST, PROD_HI_RST, PROD_LO_RST});
    chk(32'(done), 32'h0000_0000);
    rst_i = 1'b0;
    step();
    $display("test reset done");
  endtask : t_reset
  task automatic t_sgn8(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    logic [7:0] h;
    int sp;
    sp = $signed(a) * $signed(b);
    mul(a, b, p);
    go = 1'b0;
    h = p[15:8];
    // subtract other operand per sign bit
    if (b[7]) h = h - a;
    if (a[7]) h = h - b;
    pwr = '{hi_we: 1'b1, lo_we: 1'b0, data: h};
    step();
    pwr = '0;
    chk({16'h0000, hi, lo}, {16'h0000, 16'(sp)});
    $display("test signed8 done");
  endtask : t_sgn8
  task automatic t_wide(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] ll;
    logic [15:0] lh;
    logic [15:0] hl;
    logic [15:0] hh;
    logic [31:0] r;
    int sp;
    sp = $signed(a) * $signed(b);
    mul(a[7:0], b[7:0], ll);
    mul(a[15:8], b[15:8], hh);
    mul(a[7:0], b[15:8], lh);
    mul(a[15:8], b[7:0], hl);
    go = 1'b0;
    r = {hh, 16'h0000} + {8'h00, lh, 8'h00} + {8'h00, hl, 8'h00} + {16'h0000, ll};
    chk(r, 32'(a) * 32'(b));
    // signed correction from high sign bits
    if (b[15]) r = r - {a, 16'h0000};
    if (a[15]) r = r - {b, 16'h0000};
    chk(r, sp);
    step();
    $display("test wide done");
  endtask : t_wide
  // Run ceiling well above the under fifty cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    #5;
    rst_i = 1'b0;
    step();
    t_tbl();
    t_flags();
    t_direct();
    t_reset();
    t_sgn8(8'hFD, 8'h05);
    t_sgn8(8'h80, 8'h80);
    t_sgn8(8'h7F, 8'h81);
    t_wide(16'hFFFF, 16'hFFFF);
    t_wide(16'h8000, 16'h7FFF);
    t_wide(16'h1234, 16'hABCD);
    test_done();
  end
endmodule : testbench
